/* logic/wdt_defines.vh */
// offsets, field positions, reset values and counts of the watchdog
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define ADDR_CLOCK_SELECT  16'hff42
`define ADDR_MODE_CONTROL  16'hfff9
`define CLOCK_SELECT_RESET 8'h00
`define MODE_CONTROL_RESET 8'h00
`define CLOCK_SELECT_MASK  8'h07
`define MODE_CONTROL_MASK  8'h98
`define RESTART_BIT_POS    7
`define MODE_HI_BIT_POS    4
`define MODE_LO_BIT_POS    3
`define SEL_DIV16          3'h0
`define SEL_DIV64          3'h2
`define SEL_DIV256         3'h4
`define SEL_DIV1024        3'h6
`define PRESCALER_WIDTH    10
`define COUNTER_WIDTH      7
`endif

/* logic/wdt_prescaler.v */
// free-running main clock prescaler with selectable tick
`timescale 1ns/100ps
`include "wdt_defines.vh"
module wdt_prescaler #(
    parameter WIDTH = `PRESCALER_WIDTH
) (
    input  wire       sys_clk_in,
    input  wire       rst_in,
    input  wire       run_in,
    input  wire [2:0] sel_in,
    output reg        tick_out
);
    reg [WIDTH-1:0] div_q;
    reg             tick_d;

    // never cleared by restart, hence early first overflow
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q    <= {WIDTH{1'b0}};
            tick_out <= 1'b0;
        end else if (run_in) begin
            div_q    <= div_q + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_out <= tick_d;
        end else begin
            tick_out <= 1'b0;
        end
    end

    // prohibited codes fall to the nearest lower even setting
    always @* begin
        case (sel_in & 3'h6)
            `SEL_DIV16:  tick_d = (div_q[3:0] == 4'hf);
            `SEL_DIV64:  tick_d = (div_q[5:0] == 6'h3f);
            `SEL_DIV256: tick_d = (div_q[7:0] == 8'hff);
            default:     tick_d = (div_q[9:0] == 10'h3ff);
        endcase
    end
endmodule // wdt_prescaler

/* logic/wdt_core.v */
// program loop watchdog timer with interval mode
`timescale 1ns/100ps
`include "wdt_defines.vh"
module wdt_core (
    input  wire        sys_clk_in,
    input  wire        rst_in,
    input  wire [15:0] addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_byte_in,
    input  wire        wr_bit_in,
    input  wire [2:0]  bit_sel_in,
    input  wire        rd_in,
    input  wire        stop_mode_in,
    input  wire        irq_flag_clr_in,
    input  wire        wdt_irq_mask_in,
    output reg  [7:0]  rdata_out,
    output reg         wdt_irq_flag_out,
    output reg         wdt_maskable_irq_out,
    output reg         nmi_out,
    output reg         sys_reset_out
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg  [2:0]                  wdt_clock_select_q;
    reg                         restart_bit_q;
    reg                         mode_hi_bit_q;
    reg                         mode_lo_bit_q;
    reg  [`COUNTER_WIDTH-1:0]   count_q;
    reg  [7:0]                  wval_d;
    wire                        tick;
    wire                        overflow;
    wire                        sel_wr;
    wire                        mode_wr;
    wire                        restart_wr;
    wire                        wdog_set;
    wire                        running;
    reg  [`COUNTER_WIDTH-1:0]   count_d;
    reg                         flag_d;
    reg                         mask_irq_d;
    reg                         nmi_d;
    reg                         reset_d;
    reg  [7:0]                  rdata_d;

    // merge a bit write into the current register image
    function [7:0] merge;
        input [7:0] cur;
        input [7:0] dat;
        input [2:0] pos;
        input       is_bit;
        begin
            merge = cur;
            if (is_bit) begin
                merge[pos] = dat[0];
            end else begin
                merge = dat;
            end
        end
    endfunction

    wire [7:0] mode_img = {restart_bit_q, 2'b00, mode_hi_bit_q,
                           mode_lo_bit_q, 3'b000};

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // byte-only select
    assign sel_wr  = wr_byte_in && (addr_in == `ADDR_CLOCK_SELECT);
    assign mode_wr = (wr_byte_in || wr_bit_in)
                     && (addr_in == `ADDR_MODE_CONTROL);
    always @* begin
        wval_d = merge(mode_img, wdata_in, bit_sel_in, wr_bit_in)
                 & `MODE_CONTROL_MASK;
    end
    assign restart_wr = mode_wr && wval_d[`RESTART_BIT_POS];
    assign wdog_set   = mode_wr && wval_d[`MODE_HI_BIT_POS];
    assign running  = restart_bit_q && !stop_mode_in
                      && (mode_hi_bit_q || mode_lo_bit_q);
    assign overflow = running && tick && (&count_q);

    // ----------------------------------------
    // clock select register
    // ----------------------------------------
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wdt_clock_select_q <= 3'h0;
        end else if (sel_wr) begin
            wdt_clock_select_q <= wdata_in[2:0];
        end
    end

    // ----------------------------------------
    // mode register
    // ----------------------------------------
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            restart_bit_q      <= 1'b0;
            mode_hi_bit_q      <= 1'b0;
            mode_lo_bit_q      <= 1'b0;
        end else if (mode_wr) begin
            restart_bit_q <= restart_bit_q | wval_d[`RESTART_BIT_POS];
            mode_hi_bit_q <= mode_hi_bit_q | wval_d[`MODE_HI_BIT_POS];
            mode_lo_bit_q <= mode_lo_bit_q | wval_d[`MODE_LO_BIT_POS];
        end
    end

    wdt_prescaler #(
        .WIDTH (`PRESCALER_WIDTH)
    ) wdt_prescaler_i (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .run_in     (!stop_mode_in),
        .sel_in     (wdt_clock_select_q),
        .tick_out   (tick)
    );

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always @* begin
        count_d = count_q;
        if (restart_wr) begin
            count_d = {`COUNTER_WIDTH{1'b0}};
        end else if (running && tick) begin
            count_d = count_q + {{(`COUNTER_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= {`COUNTER_WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    // ----------------------------------------
    // next values of the event outputs
    // ----------------------------------------
    // set wins over clear
    always @* begin
        flag_d = overflow || (wdt_irq_flag_out && !irq_flag_clr_in);
    end

    always @* begin
        mask_irq_d = overflow && !mode_hi_bit_q && !wdt_irq_mask_in;
    end

    always @* begin
        nmi_d = overflow && mode_hi_bit_q && !mode_lo_bit_q;
        if (wdog_set && wdt_irq_flag_out) begin
            nmi_d = 1'b1;
        end
    end

    always @* begin
        reset_d = overflow && mode_hi_bit_q && mode_lo_bit_q;
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    always @* begin
        if (rd_in && addr_in == `ADDR_CLOCK_SELECT) begin
            rdata_d = {5'h00, wdt_clock_select_q};
        end else if (rd_in && addr_in == `ADDR_MODE_CONTROL) begin
            rdata_d = mode_img;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // every output straight from a flop, so no glitch reaches the cpu
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wdt_irq_flag_out     <= 1'b0;
            wdt_maskable_irq_out <= 1'b0;
            nmi_out              <= 1'b0;
            sys_reset_out        <= 1'b0;
            rdata_out            <= 8'h00;
        end else begin
            wdt_irq_flag_out     <= flag_d;
            wdt_maskable_irq_out <= mask_irq_d;
            nmi_out              <= nmi_d;
            sys_reset_out        <= reset_d;
            rdata_out            <= rdata_d;
        end
    end
endmodule // wdt_core

/* bench/wdt_core_monitor.sv */
// concurrent checks on the watchdog core ports
`timescale 1ns/100ps
module wdt_core_monitor (
    input wire        sys_clk_in,
    input wire        rst_in,
    input wire [15:0] addr_in,
    input wire        rd_in,
    input wire        stop_mode_in,
    input wire        wdt_irq_mask_in,
    input wire [7:0]  rdata_out,
    input wire        wdt_irq_flag_out,
    input wire        wdt_maskable_irq_out,
    input wire        nmi_out,
    input wire        sys_reset_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_unmapped_read_zero: assert property (
        rd_in && addr_in != 16'hff42 && addr_in != 16'hfff9 |=>
        rdata_out == 8'h00) else $error("unmapped read not zero");
    a_select_fixed_zero: assert property (
        rd_in && addr_in == 16'hff42 |=> rdata_out[7:3] == 5'h00)
        else $error("select upper bits not zero");
    a_mode_fixed_zero: assert property (
        rd_in && addr_in == 16'hfff9 |=> (rdata_out & 8'h67) == 8'h00)
        else $error("mode fixed bits not zero");
    a_irq_sets_flag: assert property (
        wdt_maskable_irq_out |-> wdt_irq_flag_out)
        else $error("interval request without flag");
    // hazard: mask sampled one edge before the registered request
    a_mask_blocks_irq: assert property (
        wdt_irq_mask_in && $past(wdt_irq_mask_in) |-> !wdt_maskable_irq_out)
        else $error("masked request escaped");
    a_stop_holds_still: assert property (
        stop_mode_in [*3] |-> !wdt_maskable_irq_out && !sys_reset_out)
        else $error("overflow while stopped");
    a_nmi_one_cycle: assert property (
        nmi_out |=> !nmi_out) else $error("nmi longer than one cycle");
    a_single_action: assert property (
        !(nmi_out && sys_reset_out)) else $error("nmi and reset together");
endmodule // wdt_core_monitor

/* bench/test_wdt_core.sv */
// self-checking bench for the watchdog core
`timescale 1ns/100ps
module test_wdt_core;
    reg         sys_clk_in, rst_in, wr_byte_in, wr_bit_in, rd_in, rd_q;
    reg         stop_mode_in, irq_flag_clr_in, wdt_irq_mask_in;
    reg  [15:0] addr_in;
    reg  [7:0]  wdata_in, d;
    reg  [2:0]  bit_sel_in;
    wire [7:0]  rdata_out;
    wire        wdt_irq_flag_out, wdt_maskable_irq_out, nmi_out, sys_reset_out;
    wire [2:0]  ev = {sys_reset_out, nmi_out, wdt_maskable_irq_out};
    integer     err_total, total_checks, seed, n;
    reg  [7:0]  exp_q[$];
    wdt_core wdt_core_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_byte_in(wr_byte_in),
        .wr_bit_in(wr_bit_in), .bit_sel_in(bit_sel_in), .rd_in(rd_in),
        .stop_mode_in(stop_mode_in), .irq_flag_clr_in(irq_flag_clr_in),
        .wdt_irq_mask_in(wdt_irq_mask_in), .rdata_out(rdata_out),
        .wdt_irq_flag_out(wdt_irq_flag_out), .nmi_out(nmi_out),
        .wdt_maskable_irq_out(wdt_maskable_irq_out),
        .sys_reset_out(sys_reset_out));
    task check(input [7:0] seen, input [7:0] want);
        total_checks = total_checks + 1;
        if (seen !== want) begin
            err_total = err_total + 1;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task end_sim;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // bit writes carry data in wdata_in[0], position in bit_sel_in
    task wr(input [15:0] a, input [7:0] v, input b, input [2:0] s);
        @(posedge sys_clk_in);
        {addr_in, wdata_in, bit_sel_in} <= {a, v, s};
        {wr_byte_in, wr_bit_in} <= {!b, b};
        @(posedge sys_clk_in);
        {wr_byte_in, wr_bit_in} <= 2'b00;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
    endtask
    // w: 0 interval request, 1 nmi, 2 system reset
    task wt(input integer w, input integer lim, input integer must);
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n = n + 1;
        end while (ev[w] !== 1'b1 && n < lim);
        if (must && n >= lim) begin
            check(8'h00, 8'h01);
            end_sim;
        end
    endtask
    task rstd;
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // read data is registered, so it is judged one edge after the strobe
    always @(posedge sys_clk_in) begin
        if (rd_q === 1'b1) check(rdata_out, exp_q.pop_front());
        rd_q <= rd_in;
    end
    initial begin
        {err_total, total_checks, seed} = {32'h0, 32'h0, 32'd65127};
        {rst_in, wr_byte_in, wr_bit_in, rd_in} = 4'h8;
        {stop_mode_in, irq_flag_clr_in, wdt_irq_mask_in} = 3'h0;
        {addr_in, wdata_in, bit_sel_in} = 27'h0;
        rstd;
        rd(16'hff42, 8'h00);
        rd(16'hfff9, 8'h00);
        rd(16'h0042, 8'h00);
        wr(16'hff42, 8'h01, 1, 3'h0);
        rd(16'hff42, 8'h00);
        d = $random(seed);
        wr(16'hff42, d, 0, 3'h0);
        rd(16'hff42, d & 8'h07);
        wr(16'hff42, 8'h00, 0, 3'h0);
        wr(16'hfff9, 8'h01, 1, 3'h7);
        wr(16'hfff9, 8'h01, 1, 3'h3);
        // zero writes must leave restart and mode bits standing
        wr(16'hfff9, 8'h00, 0, 3'h0);
        wr(16'hfff9, 8'h00, 1, 3'h3);
        rd(16'hfff9, 8'h88);
        wt(0, 2100, 1);
        check(n > 2000, 1);
        wt(0, 2100, 1);
        check(n == 2048, 1);
        @(posedge sys_clk_in) irq_flag_clr_in <= 1'b1;
        @(posedge sys_clk_in) {irq_flag_clr_in, wdt_irq_mask_in} <= 2'b01;
        @(negedge sys_clk_in) check(wdt_irq_flag_out, 0);
        wt(0, 2100, 0);
        check(n == 2100, 1);
        check(wdt_irq_flag_out, 1);
        wr(16'hfff9, 8'h80, 0, 3'h0);
        @(posedge sys_clk_in) {stop_mode_in, wdt_irq_mask_in} <= 2'b10;
        wt(0, 3000, 0);
        check(n == 3000, 1);
        @(posedge sys_clk_in) stop_mode_in <= 1'b0;
        wt(0, 2100, 1);
        rstd;
        check(wdt_irq_flag_out, 0);
        wr(16'hfff9, 8'h98, 0, 3'h0);
        repeat (2) begin
            wt(2, 1500, 0);
            check(n == 1500, 1);
            wr(16'hfff9, 8'h80, 0, 3'h0);
        end
        rd(16'hfff9, 8'h98);
        wt(2, 2100, 1);
        check(n > 2000, 1);
        rstd;
        check(wdt_irq_flag_out, 0);
        wr(16'hfff9, 8'h90, 0, 3'h0);
        wt(1, 2100, 1);
        // flag still set from that overflow, so a mode rewrite fires at once
        wr(16'hfff9, 8'h01, 1, 3'h4);
        wt(1, 3, 1);
        check(n < 3, 1);
        end_sim;
    end
endmodule // test_wdt_core
bind wdt_core wdt_core_monitor wdt_core_monitor_i (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .rd_in(rd_in),
    .stop_mode_in(stop_mode_in), .wdt_irq_mask_in(wdt_irq_mask_in),
    .rdata_out(rdata_out), .wdt_irq_flag_out(wdt_irq_flag_out),
    .wdt_maskable_irq_out(wdt_maskable_irq_out), .nmi_out(nmi_out),
    .sys_reset_out(sys_reset_out));
